/* rtl/adcab_conv.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adcab_regs.svh"
module adcab_conv
  import adcab_pkg::*;
#(
  parameter int CONV_CYCLES = `ADCAB_CONV_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] conv_sample,
  adcab_cv_if.cvt          cv
);

  adcab_cv_state_t s_q;
  adcab_cv_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    // abort drops the sample, no done pulse follows
    if (cv.abort) begin
      s_d.busy = 1'b0;
    end else if (cv.start) begin
      s_d.busy = 1'b1;
      s_d.cnt  = 8'(CONV_CYCLES - 1);
    end else if (s_q.busy) begin
      if (s_q.cnt == 8'h00) begin
        s_d.busy   = 1'b0;
        s_d.done   = 1'b1;
        s_d.result = conv_sample;
      end else begin
        s_d.cnt = s_q.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cv.done   = s_q.done;
  assign cv.result = s_q.result;

endmodule
`default_nettype wire

/* rtl/adcab_cv_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface adcab_cv_if;
  logic        start;
  logic        abort;
  logic [3:0]  chan;
  logic        done;
  logic [11:0] result;

  modport seq (output start, output abort, output chan,
               input done, input result);
  modport cvt (input start, input abort, input chan,
               output done, output result);
endinterface
`default_nettype wire

/* rtl/adcab_pkg.sv */
package adcab_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_CONV} adcab_st_t;

  typedef struct packed {
    adcab_st_t   st;
    logic        is_inj;
    logic        is_ctu;
    logic [3:0]  idx;
    logic [3:0]  ctu_ch;
    logic        nrm_pend;
    logic        inj_pend;
    logic        abt_ch;
    logic        abt_chain;
    logic        flg_nrm;
    logic        flg_inj;
    logic        flg_ch;
    logic        ctu_hung;
    logic        ctu_ack;
    logic [7:0]  nmask;
    logic [7:0]  imask;
    logic [11:0] data;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [7:0]  wdata;
    logic        wstb0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } adcab_state_t;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [7:0]  cnt;
    logic [11:0] result;
  } adcab_cv_state_t;

endpackage

/* rtl/adcab_regs.svh */
`ifndef ADCAB_REGS_SVH
`define ADCAB_REGS_SVH

// register byte offsets
`define ADCAB_MAIN_CONFIG_OFS  8'h00
`define ADCAB_MAIN_STATUS_OFS  8'h04
`define ADCAB_FLAGS_OFS        8'h08
`define ADCAB_NORMAL_MASK_OFS  8'h0c
`define ADCAB_INJ_MASK_OFS     8'h10
`define ADCAB_DATA_OFS         8'h14

// main_config_reg fields
`define ADCAB_CFG_NRM_START    0
`define ADCAB_CFG_INJ_START    1
`define ADCAB_CFG_CHAN_ABORT   2
`define ADCAB_CFG_CHAIN_ABORT  3

// main_status_reg fields
`define ADCAB_STA_NRM_RUN      0
`define ADCAB_STA_INJ_RUN      1
`define ADCAB_STA_CTU_STALL    2
`define ADCAB_STA_CHAN_LSB     4

// flag register fields, write one to clear
`define ADCAB_FLG_NRM_END      0
`define ADCAB_FLG_INJ_END      1
`define ADCAB_FLG_CHAN_END     2

// reset values
`define ADCAB_NMASK_RST        8'h00
`define ADCAB_IMASK_RST        8'h00

// sizes
`define ADCAB_NCH              8
`define ADCAB_SAMPLE_W         12

// axi responses
`define ADCAB_RESP_OKAY        2'b00
`define ADCAB_RESP_SLVERR      2'b10

// timing
`define ADCAB_CLK_HZ           10000000
`define ADCAB_CONV_NS          1000
`define ADCAB_CONV_CYC \
  ((`ADCAB_CONV_NS * (`ADCAB_CLK_HZ / 1000000) + 999) / 1000)

`endif

/* rtl/adcab_top.sv */
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "adcab_regs.svh"
module adcab_top
  import adcab_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        ctu_req,
  input  wire logic [3:0]  ctu_chan,
  output logic             ctu_ack,
  input  wire logic [11:0] conv_sample
);

  adcab_state_t s;
  adcab_state_t n;
  adcab_cv_if   cv ();

  logic       wr_fire;
  logic       wr_cfg;
  logic       take_ctu;
  logic       take_inj;
  logic       take_nrm;
  logic       sel_hit;
  logic       cv_start;
  logic       cv_abort;
  logic [7:0] mask;

  adcab_conv u_conv (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .conv_sample (conv_sample),
    .cv          (cv)
  );

  assign cv.start = cv_start;
  assign cv.abort = cv_abort;
  assign cv.chan  = s.idx;

  always_comb begin
    n        = s;
    n.ctu_ack = 1'b0;
    cv_start = 1'b0;
    cv_abort = 1'b0;
    wr_fire  = s.aw_got && s.w_got && !s.bvalid;
    wr_cfg   = wr_fire && s.wstb0 && (s.awaddr == `ADCAB_MAIN_CONFIG_OFS);
    // trigger unit wins over software starts
    take_ctu = (s.st == ST_IDLE) && ctu_req && !s.ctu_hung && !s.ctu_ack;
    take_inj = (s.st == ST_IDLE) && !take_ctu && s.inj_pend;
    take_nrm = (s.st == ST_IDLE) && !take_ctu && !take_inj && s.nrm_pend;
    mask     = s.is_inj ? s.imask : s.nmask;
    sel_hit  = s.is_ctu ? (s.idx == s.ctu_ch) : mask[s.idx[2:0]];

    // flag clear first so a same-cycle hardware set wins
    if (wr_fire && s.wstb0 && (s.awaddr == `ADCAB_FLAGS_OFS)) begin
      if (s.wdata[`ADCAB_FLG_NRM_END]) n.flg_nrm = 1'b0;
      if (s.wdata[`ADCAB_FLG_INJ_END]) n.flg_inj = 1'b0;
      if (s.wdata[`ADCAB_FLG_CHAN_END]) n.flg_ch = 1'b0;
    end

    case (s.st)
      ST_IDLE: begin
        if (take_ctu || take_inj || take_nrm) begin
          n.is_ctu = take_ctu;
          n.is_inj = take_ctu || take_inj;
          n.ctu_ch = ctu_chan;
          n.idx    = 4'h0;
          if (take_inj) n.inj_pend = 1'b0;
          if (take_nrm) n.nrm_pend = 1'b0;
          if ((take_ctu || take_inj) && s.abt_chain) begin
            n.st = ST_IDLE;
            if (take_ctu) n.ctu_hung = 1'b1;
          end else begin
            n.st = ST_SCAN;
            if (s.abt_ch) n.abt_ch = 1'b0;
          end
        end
      end
      ST_SCAN: begin
        if (s.abt_chain) begin
          n.abt_chain = 1'b0;
          n.st        = ST_IDLE;
          if (s.is_inj) n.flg_inj = 1'b1;
          else n.flg_nrm = 1'b1;
          if (s.is_ctu) n.ctu_ack = 1'b1;
        end else if (s.idx == 4'(`ADCAB_NCH)) begin
          n.st = ST_IDLE;
          if (s.is_inj) n.flg_inj = 1'b1;
          else n.flg_nrm = 1'b1;
          if (s.is_ctu) n.ctu_ack = 1'b1;
        end else if (sel_hit) begin
          cv_start = 1'b1;
          n.st     = ST_CONV;
        end else begin
          n.idx = s.idx + 4'h1;
        end
      end
      ST_CONV: begin
        if (s.abt_chain) begin
          cv_abort    = 1'b1;
          n.abt_chain = 1'b0;
          n.st        = ST_IDLE;
          if (s.is_inj) n.flg_inj = 1'b1;
          else n.flg_nrm = 1'b1;
          if (s.is_ctu) n.ctu_ack = 1'b1;
        end else if (s.abt_ch) begin
          cv_abort = 1'b1;
          n.abt_ch = 1'b0;
          n.idx    = s.idx + 4'h1;
          n.st     = ST_SCAN;
        end else if (cv.done) begin
          n.data   = cv.result;
          n.flg_ch = 1'b1;
          n.idx    = s.idx + 4'h1;
          n.st     = ST_SCAN;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // software sets after hardware clears; writing zero cancels nothing
    if (wr_cfg) begin
      if (s.wdata[`ADCAB_CFG_NRM_START]) n.nrm_pend = 1'b1;
      if (s.wdata[`ADCAB_CFG_INJ_START]) n.inj_pend = 1'b1;
      if (s.wdata[`ADCAB_CFG_CHAN_ABORT]) n.abt_ch = 1'b1;
      if (s.wdata[`ADCAB_CFG_CHAIN_ABORT]) n.abt_chain = 1'b1;
    end
    if (wr_fire && s.wstb0 && (s.awaddr == `ADCAB_NORMAL_MASK_OFS)) begin
      n.nmask = s.wdata;
    end
    if (wr_fire && s.wstb0 && (s.awaddr == `ADCAB_INJ_MASK_OFS)) begin
      n.imask = s.wdata;
    end

    // write channels taken independently, answered when both held
    if (awvalid && s.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_got = 1'b1;
      n.wdata = wdata[7:0];
      n.wstb0 = wstrb[0];
    end
    if (wr_fire) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = (s.awaddr[1:0] == 2'b00 && s.awaddr <= `ADCAB_DATA_OFS)
               ? `ADCAB_RESP_OKAY : `ADCAB_RESP_SLVERR;
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;

    // reads answer one cycle after the address is taken
    if (arvalid && s.arready) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rresp   = `ADCAB_RESP_OKAY;
      n.rdata   = 32'h0000_0000;
      case (araddr)
        `ADCAB_MAIN_CONFIG_OFS: begin
          n.rdata[`ADCAB_CFG_NRM_START]   = s.nrm_pend;
          n.rdata[`ADCAB_CFG_INJ_START]   = s.inj_pend;
          n.rdata[`ADCAB_CFG_CHAN_ABORT]  = s.abt_ch;
          n.rdata[`ADCAB_CFG_CHAIN_ABORT] = s.abt_chain;
        end
        `ADCAB_MAIN_STATUS_OFS: begin
          n.rdata[`ADCAB_STA_NRM_RUN]   = (s.st != ST_IDLE) && !s.is_inj;
          n.rdata[`ADCAB_STA_INJ_RUN]   = (s.st != ST_IDLE) && s.is_inj;
          n.rdata[`ADCAB_STA_CTU_STALL] = s.ctu_hung;
          n.rdata[`ADCAB_STA_CHAN_LSB +: 4] = s.idx;
        end
        `ADCAB_FLAGS_OFS: begin
          n.rdata[`ADCAB_FLG_NRM_END]  = s.flg_nrm;
          n.rdata[`ADCAB_FLG_INJ_END]  = s.flg_inj;
          n.rdata[`ADCAB_FLG_CHAN_END] = s.flg_ch;
        end
        `ADCAB_NORMAL_MASK_OFS: n.rdata[7:0] = s.nmask;
        `ADCAB_INJ_MASK_OFS:    n.rdata[7:0] = s.imask;
        `ADCAB_DATA_OFS:        n.rdata[11:0] = s.data;
        default:                n.rresp = `ADCAB_RESP_SLVERR;
      endcase
    end
    if (s.rvalid && rready) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.nmask   <= `ADCAB_NMASK_RST;
      s.imask   <= `ADCAB_IMASK_RST;
      s.arready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign awready = s.awready;
  assign wready  = s.wready;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.arready;
  assign rvalid  = s.rvalid;
  assign rdata   = s.rdata;
  assign rresp   = s.rresp;
  assign ctu_ack = s.ctu_ack;

  // injected start with chain abort pending
  inj_pre_abort_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (take_inj && s.abt_chain) |=>
      (s.st == ST_IDLE) && s.abt_chain && !$rose(s.flg_inj))
    else $error("injected chain not silently aborted");

  ctu_no_ack_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (take_ctu && s.abt_chain) |=> (s.ctu_hung && !s.ctu_ack) [*8])
    else $error("aborted trigger conversion was acknowledged");

  ctu_hang_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s.ctu_hung |=> s.ctu_hung && !s.ctu_ack)
    else $error("trigger unit stall released before reset");

  stale_chan_clr_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((take_nrm || take_inj) && !s.abt_chain && s.abt_ch &&
     !(wr_cfg && s.wdata[`ADCAB_CFG_CHAN_ABORT])) |=>
      !s.abt_ch && (s.st == ST_SCAN) && (s.idx == 4'h0))
    else $error("pre-set channel abort not dropped at start");

  chain_abort_end_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((s.st != ST_IDLE) && s.abt_chain &&
     !(wr_cfg && s.wdata[`ADCAB_CFG_CHAIN_ABORT])) |=>
      (s.st == ST_IDLE) && !s.abt_chain && (s.flg_inj || s.flg_nrm))
    else $error("running chain abort mishandled");

  chan_abort_skip_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((s.st == ST_CONV) && s.abt_ch && !s.abt_chain) |=>
      (s.st == ST_SCAN) && (s.idx == $past(s.idx) + 4'h1))
    else $error("channel abort did not move to next channel");

  ack_pulse_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s.ctu_ack |=> !s.ctu_ack && ($past(s.st) == ST_IDLE))
    else $error("trigger acknowledge longer than one cycle");

  bresp_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s.bvalid && !bready) |=> s.bvalid && $stable(s.bresp))
    else $error("write response dropped before taken");

  rdata_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s.rvalid && !rready) |=> s.rvalid && $stable(s.rdata))
    else $error("read data changed before taken");

endmodule
`default_nettype wire

/* verification/adcab_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adcab_regs.svh"
module adcab_top_tb_top;
  logic        aclk;
  logic        aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0, go = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, ctu_req, ctu_ack;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [3:0]  wstrb = 4'h0, go_ch = 4'h0, ctu_chan;
  logic [1:0]  bresp, rresp, rs;
  logic [11:0] conv_sample = 12'h000;
  int          fail_count = 0, checked = 0, cyc = 0, acks, a0, n;

  adcab_top dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .ctu_req, .ctu_chan,
    .ctu_ack, .conv_sample);
  adcab_trig_model trig (.aclk, .aresetn, .go, .go_ch, .ctu_req,
    .ctu_chan, .ctu_ack, .acks);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard, whole run needs about 400 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // polls flags; bound covers a full eight channel chain
  task automatic wflag(input int b);
    for (int i = 0; i < 60; i++) begin
      rd(8'h08);
      if (v[b] === 1'b1) break;
    end
  endtask

  task automatic fire(input logic [3:0] c);
    @(posedge aclk);
    go_ch <= c;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask

  task automatic t_reset;
    rd(8'h04);
    chk(v, 32'h0);
    rd(8'h08);
    chk(v, 32'h0);
    rd(8'h40);
    chk(v, 32'h0);
    chk(rs, `ADCAB_RESP_SLVERR);
    wr(8'h42, 32'h1);
    chk(rs, `ADCAB_RESP_SLVERR);
    $display("test reset done");
  endtask

  task automatic t_trig_ok;
    conv_sample <= 12'h5a3;
    a0 = acks;
    fire(4'h3);
    for (n = 0; n < 80 && acks == a0; n++) @(posedge aclk);
    chk(32'(acks - a0), 32'h1);
    chk(32'(n >= 11), 32'h1);
    rd(8'h14);
    chk(v, 32'h5a3);
    $display("test trigger done");
  endtask

  task automatic t_pre_chan;
    conv_sample <= 12'h2c1;
    wr(8'h0c, 32'h1);
    wr(8'h00, 32'h4);
    wr(8'h00, 32'h1);
    wflag(0);
    chk(v[0], 1'b1);
    rd(8'h14);
    chk(v, 32'h2c1);
    wr(8'h08, 32'h7);
    $display("test early channel abort done");
  endtask

  // aborts only once the chain runs
  task automatic t_run_chan;
    conv_sample <= 12'h0f0;
    wr(8'h0c, 32'h3);
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h4);
    rd(8'h04);
    chk(v[7:0], 8'h11);
    wflag(0);
    chk(v[0], 1'b1);
    wr(8'h08, 32'h7);
    $display("test running channel abort done");
  endtask

  task automatic t_run_chain;
    wr(8'h0c, 32'hff);
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h8);
    repeat (3) @(posedge aclk);
    rd(8'h04);
    chk(v[0], 1'b0);
    rd(8'h08);
    chk(v[0], 1'b1);
    rd(8'h00);
    chk(v[3], 1'b0);
    wr(8'h08, 32'h7);
    $display("test running chain abort done");
  endtask

  task automatic t_inj_run;
    conv_sample <= 12'h3c5;
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h2);
    rd(8'h04);
    chk(v[1:0], 2'b10);
    wflag(1);
    chk(v[2:0], 3'b110);
    rd(8'h14);
    chk(v, 32'h3c5);
    wr(8'h08, 32'h7);
    rd(8'h08);
    chk(v, 32'h0);
    $display("test injected chain done");
  endtask

  // normal mask cleared, then wait for idle
  task automatic t_mask_stop;
    wr(8'h0c, 32'hff);
    wr(8'h00, 32'h1);
    wr(8'h0c, 32'h0);
    for (int i = 0; i < 15; i++) begin
      rd(8'h04);
      if (v[0] === 1'b0) break;
    end
    chk(v[0], 1'b0);
    rd(8'h08);
    chk(v[0], 1'b1);
    wr(8'h0c, 32'hff);
    rd(8'h0c);
    chk(v, 32'hff);
    wr(8'h08, 32'h7);
    $display("test mask stop done");
  endtask

  task automatic t_pre_chain;
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h8);
    wr(8'h00, 32'h2);
    repeat (30) @(posedge aclk);
    rd(8'h08);
    chk(v[1], 1'b0);
    rd(8'h04);
    chk(v[1:0], 2'b00);
    rd(8'h00);
    chk(v[3], 1'b1);
    $display("test early chain abort done");
  endtask

  // abort request left set breaks the advice on purpose
  task automatic t_hang;
    a0 = acks;
    fire(4'h2);
    repeat (40) @(posedge aclk);
    chk(32'(acks - a0), 32'h0);
    rd(8'h04);
    chk(v[2], 1'b1);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h04);
    chk(v, 32'h0);
    $display("test trigger hang done");
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_trig_ok();
    t_pre_chan();
    t_run_chan();
    t_run_chain();
    t_inj_run();
    t_mask_stop();
    t_pre_chain();
    t_hang();
    t_trig_ok();
    end_of_test();
  end
endmodule
`default_nettype wire

/* verification/adcab_trig_model.sv */
`timescale 1ns/1ps
`default_nettype none
module adcab_trig_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go,
  input  wire logic [3:0] go_ch,
  output logic            ctu_req,
  output logic [3:0]      ctu_chan,
  input  wire logic       ctu_ack,
  output int              acks
);
  initial begin
    ctu_req = 1'b0;
    ctu_chan = 4'h0;
    acks = 0;
  end

  // holds request until ack or reset, no timeout
  always @(posedge aclk) begin
    if (ctu_ack) begin
      acks <= acks + 1;
    end
    if (!aresetn) begin
      ctu_req <= 1'b0;
    end else if (ctu_req && ctu_ack) begin
      ctu_req <= 1'b0;
      // channel lines inverted once released, no longer valid
      ctu_chan <= ~ctu_chan;
    end else if (go && !ctu_req) begin
      ctu_req <= 1'b1;
      ctu_chan <= go_ch;
    end
  end
endmodule
`default_nettype wire
